// [common/panel_pkg.sv]
// Shared constants and types of the operator panel block
package panel_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int MS_WIDTH       = 11;

    // Blink phases in milliseconds: 0.35 s, 0.15 s, 0.95 s, 1.2 s
    localparam logic [10:0] BLINK1_ON_MS  = 11'd350;
    localparam logic [10:0] BLINK1_OFF_MS = 11'd150;
    localparam logic [10:0] BLINK2_ON_MS  = 11'd950;
    localparam logic [10:0] BLINK2_OFF_MS = 11'd1200;
    // Set key hold of one second
    localparam logic [10:0] HOLD_MS       = 11'd1000;
    // Upper and lower half alternation period
    localparam logic [10:0] ALT_MS        = 11'd1000;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;
    localparam logic [7:0] ADDR_STATION    = 8'h10;
    localparam logic [7:0] ADDR_PARAM      = 8'h14;
    localparam logic [7:0] ADDR_POSN       = 8'h18;

    localparam logic [6:0]  MODE_ENABLE_RESET = 7'h7f;
    localparam logic [3:0]  IRQ_MASK_RESET    = 4'h0;
    localparam logic [7:0]  STATION_RESET     = 8'h01;
    localparam logic [19:0] EDIT_RESET        = 20'h00000;

    // Interrupt status bits
    localparam int IRQ_MODE  = 0;
    localparam int IRQ_OPEN  = 1;
    localparam int IRQ_EDIT  = 2;
    localparam int IRQ_ALARM = 3;

    // Display glyphs beyond hex digits
    localparam logic [4:0] GLYPH_BLANK = 5'h10;
    localparam logic [4:0] GLYPH_UPPER = 5'h11;
    localparam logic [4:0] GLYPH_LOWER = 5'h12;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        LAMP_DARK   = 2'b00,
        LAMP_STEADY = 2'b01,
        LAMP_BLINK1 = 2'b11,
        LAMP_BLINK2 = 2'b10
    } lamp_type;

    typedef enum logic [2:0] {
        MODE_SEQ   = 3'b000,
        MODE_MON   = 3'b001,
        MODE_STN   = 3'b011,
        MODE_MAINT = 3'b010,
        MODE_PARAM = 3'b110,
        MODE_POSN  = 3'b111,
        MODE_TEST  = 3'b101
    } mode_type;

endpackage

// [hdl/ms_counter.sv]
// Millisecond counter with restart and terminal flag
`timescale 1ns/1ps
module ms_counter #(
    parameter int WIDTH = 11
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // Control
    input  wire logic             restart,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] limit,
    // Result
    output logic      [WIDTH-1:0] count,
    output logic                  done
);

    always_ff @(posedge sys_clk) begin
        if (srst || restart) begin
            count <= '0;
        end else if (tick && count != limit) begin
            count <= count + 1'b1;
        end
    end

    assign done = (count == limit);

endmodule

// [hdl/operator_panel.sv]
// Operator panel: status lamp, six-digit display, keys and modes
`timescale 1ns/1ps
// Contract
// - Lamp steadily lit while online and servo ready.
// - Alarm or battery warning blinks lamp 0.35 s on, 0.15 s off.
// - Sequence test blinks lamp 0.95 s on, 1.2 s off.
// - Offline with dark lamp while motor-rotating test runs.
// - Six-digit display; five or more digits alternate upper/lower five.
// - Decode mode/escape, up, down and set/shift keys.
// - Seven panel modes, some may be disabled.
// - A mode/escape press with no data open steps to the next available mode.
// - Values editable only in parameter and positioning edit modes.
// - Maintenance mode shows current alarm and alarm history.
// - Station mode shows configured station number.
// - Test mode commands motor motion from keys.
module operator_panel
    import panel_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_strobe,
    input  wire logic        rd_strobe,
    output logic      [31:0] rd_data,
    output logic             irq,
    // Panel keys, high while pressed
    input  wire logic        mode_escape_key,
    input  wire logic        up_key,
    input  wire logic        down_key,
    input  wire logic        set_shift_key,
    // Amplifier status
    input  wire logic        servo_ready,
    input  wire logic        alarm_active,
    input  wire logic        battery_warning,
    input  wire logic        seq_test_active,
    input  wire logic        loader_test_active,
    // Display data, one nibble per digit
    input  wire logic [39:0] seq_value,
    input  wire logic [39:0] monitor_value,
    input  wire logic [39:0] alarm_present,
    input  wire logic [39:0] alarm_history,
    // Outputs
    output logic             lamp_on,
    output logic [41:0]      segments,
    output logic             jog_fwd,
    output logic             jog_rev,
    output logic             offline
);

    // ************************************************************
    // Millisecond tick
    // ************************************************************
    logic [16:0] tick_count;
    logic        tick;

    always_ff @(posedge sys_clk) begin
        if (srst || tick) begin
            tick_count <= 17'h00000;
        end else begin
            tick_count <= tick_count + 17'h00001;
        end
    end

    assign tick = (tick_count == 17'(TICK_LEN - 1));

    // ************************************************************
    // Registers
    // ************************************************************
    logic [6:0]  mode_enable;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [7:0]  station;
    logic [19:0] param_value;
    logic [19:0] posn_value;
    logic [3:0]  events;
    mode_type    mode;
    lamp_type    lamp_state;
    logic        opened;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_enable <= MODE_ENABLE_RESET;
            irq_mask    <= IRQ_MASK_RESET;
            station     <= STATION_RESET;
        end else if (wr_strobe) begin
            if (addr == ADDR_CTRL)     mode_enable <= wr_data[6:0];
            if (addr == ADDR_IRQ_MASK) irq_mask    <= wr_data[3:0];
            if (addr == ADDR_STATION)  station     <= wr_data[7:0];
        end
    end

    // Read clears, a new event in the same cycle wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_status <= 4'h0;
        end else if (rd_strobe && addr == ADDR_IRQ_STATUS) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data <= 32'h00000000;
        end else if (rd_strobe) begin
            case (addr)
                ADDR_CTRL:       rd_data <= {25'h0000000, mode_enable};
                ADDR_STATUS:     rd_data <= {23'h000000, offline, lamp_on, lamp_state,
                                             opened, 1'b0, mode};
                ADDR_IRQ_STATUS: rd_data <= {28'h0000000, irq_status};
                ADDR_IRQ_MASK:   rd_data <= {28'h0000000, irq_mask};
                ADDR_STATION:    rd_data <= {24'h000000, station};
                ADDR_PARAM:      rd_data <= {12'h000, param_value};
                ADDR_POSN:       rd_data <= {12'h000, posn_value};
                default:         rd_data <= 32'h00000000;
            endcase
        end else begin
            rd_data <= 32'h00000000;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ************************************************************
    // Keys
    // ************************************************************
    logic [3:0] key_prev;
    logic       mode_press;
    logic       up_press;
    logic       down_press;
    logic       hold_done;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            key_prev <= 4'h0;
        end else begin
            key_prev <= {mode_escape_key, up_key, down_key, set_shift_key};
        end
    end

    assign mode_press = mode_escape_key && !key_prev[3];
    assign up_press   = up_key && !key_prev[2];
    assign down_press = down_key && !key_prev[1];

    // Counts held milliseconds of the set key
    ms_counter #(.WIDTH(MS_WIDTH)) u_hold (
        .sys_clk (sys_clk),
        .srst    (srst),
        .restart (!set_shift_key),
        .tick    (tick),
        .limit   (HOLD_MS),
        .count   (),
        .done    (hold_done)
    );

    // ************************************************************
    // Mode selection
    // ************************************************************
    function automatic mode_type mode_succ(mode_type m);
        case (m)
            MODE_SEQ:   return MODE_MON;
            MODE_MON:   return MODE_STN;
            MODE_STN:   return MODE_MAINT;
            MODE_MAINT: return MODE_PARAM;
            MODE_PARAM: return MODE_POSN;
            MODE_POSN:  return MODE_TEST;
            default:    return MODE_SEQ;
        endcase
    endfunction

    function automatic int mode_index(mode_type m);
        case (m)
            MODE_SEQ:   return 0;
            MODE_MON:   return 1;
            MODE_STN:   return 2;
            MODE_MAINT: return 3;
            MODE_PARAM: return 4;
            MODE_POSN:  return 5;
            default:    return 6;
        endcase
    endfunction

    mode_type next_mode;

    always_comb begin
        mode_type c;
        logic     found;
        c         = mode;
        found     = 1'b0;
        next_mode = mode;
        for (int i = 0; i < 7; i++) begin
            c = mode_succ(c);
            if (!found && mode_enable[mode_index(c)]) begin
                next_mode = c;
                found     = 1'b1;
            end
        end
    end

    // Escape closes open data, otherwise the key steps the mode
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode   <= MODE_SEQ;
            opened <= 1'b0;
        end else if (mode_press) begin
            if (opened) begin
                opened <= 1'b0;
            end else begin
                mode <= next_mode;
            end
        end else if (hold_done && !opened) begin
            opened <= 1'b1;
        end
    end

    // ************************************************************
    // Editing, maintenance page and test motion
    // ************************************************************
    logic maint_history;
    logic edit_param;
    logic edit_posn;

    assign edit_param = opened && mode == MODE_PARAM;
    assign edit_posn  = opened && mode == MODE_POSN;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            param_value <= EDIT_RESET;
            posn_value  <= EDIT_RESET;
        end else begin
            if (wr_strobe && addr == ADDR_PARAM) begin
                param_value <= wr_data[19:0];
            end else if (edit_param && up_press) begin
                param_value <= param_value + 20'h00001;
            end else if (edit_param && down_press) begin
                param_value <= param_value - 20'h00001;
            end
            if (wr_strobe && addr == ADDR_POSN) begin
                posn_value <= wr_data[19:0];
            end else if (edit_posn && up_press) begin
                posn_value <= posn_value + 20'h00001;
            end else if (edit_posn && down_press) begin
                posn_value <= posn_value - 20'h00001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !opened || mode != MODE_MAINT) begin
            maint_history <= 1'b0;
        end else if (up_press || down_press) begin
            maint_history <= !maint_history;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            jog_fwd <= 1'b0;
            jog_rev <= 1'b0;
            offline <= 1'b0;
        end else begin
            jog_fwd <= opened && mode == MODE_TEST && up_key && !down_key;
            jog_rev <= opened && mode == MODE_TEST && down_key && !up_key;
            offline <= jog_fwd || jog_rev || loader_test_active;
        end
    end

    // ************************************************************
    // Status lamp
    // ************************************************************
    lamp_type    next_lamp;
    logic [10:0] blink_limit;
    logic [10:0] blink_ms;
    logic        blink_done;
    logic        lamp_change;
    logic        alarm_prev;

    always_comb begin
        if (alarm_active || battery_warning) begin
            next_lamp = LAMP_BLINK1;
        end else if (seq_test_active) begin
            next_lamp = LAMP_BLINK2;
        end else if (!offline && servo_ready) begin
            next_lamp = LAMP_STEADY;
        end else begin
            next_lamp = LAMP_DARK;
        end
    end

    always_comb begin
        case (lamp_state)
            LAMP_BLINK1: blink_limit = lamp_on ? BLINK1_ON_MS : BLINK1_OFF_MS;
            LAMP_BLINK2: blink_limit = lamp_on ? BLINK2_ON_MS : BLINK2_OFF_MS;
            default:     blink_limit = BLINK1_ON_MS;
        endcase
    end

    assign lamp_change = (next_lamp != lamp_state);

    ms_counter #(.WIDTH(MS_WIDTH)) u_blink (
        .sys_clk (sys_clk),
        .srst    (srst),
        .restart (lamp_change || blink_done),
        .tick    (tick),
        .limit   (blink_limit),
        .count   (blink_ms),
        .done    (blink_done)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lamp_state <= LAMP_DARK;
            lamp_on    <= 1'b0;
        end else begin
            lamp_state <= next_lamp;
            case (next_lamp)
                LAMP_STEADY: lamp_on <= 1'b1;
                LAMP_BLINK1,
                LAMP_BLINK2: begin
                    if (lamp_change) begin
                        lamp_on <= 1'b1;
                    end else if (blink_done) begin
                        lamp_on <= !lamp_on;
                    end
                end
                default:     lamp_on <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alarm_prev <= 1'b0;
        end else begin
            alarm_prev <= alarm_active;
        end
    end

    assign events[IRQ_MODE]  = mode_press && !opened && next_mode != mode;
    assign events[IRQ_OPEN]  = hold_done && !opened && !mode_press;
    assign events[IRQ_EDIT]  = (edit_param || edit_posn) && (up_press || down_press);
    assign events[IRQ_ALARM] = alarm_active && !alarm_prev;

    // ************************************************************
    // Display
    // ************************************************************
    logic [39:0] shown;
    logic        alt_done;
    logic        alt_upper;
    logic        long_value;
    logic [4:0]  glyph [6];

    ms_counter #(.WIDTH(MS_WIDTH)) u_alt (
        .sys_clk (sys_clk),
        .srst    (srst),
        .restart (alt_done),
        .tick    (tick),
        .limit   (ALT_MS),
        .count   (),
        .done    (alt_done)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alt_upper <= 1'b0;
        end else if (alt_done) begin
            alt_upper <= !alt_upper;
        end
    end

    always_comb begin
        case (mode)
            MODE_SEQ:   shown = seq_value;
            MODE_MON:   shown = monitor_value;
            MODE_STN:   shown = {32'h00000000, station};
            MODE_MAINT: shown = maint_history ? alarm_history : alarm_present;
            MODE_PARAM: shown = {20'h00000, param_value};
            MODE_POSN:  shown = {20'h00000, posn_value};
            default:    shown = {38'h0000000000, jog_fwd, jog_rev};
        endcase
        if (!opened) begin
            shown = {37'h0000000000, 3'(mode_index(mode) + 1)};
        end
    end

    assign long_value = |shown[39:16];

    always_comb begin
        for (int d = 0; d < 6; d++) begin
            glyph[d] = GLYPH_BLANK;
        end
        if (long_value) begin
            // Marker digit tells which half is on view
            glyph[5] = alt_upper ? GLYPH_UPPER : GLYPH_LOWER;
            for (int d = 0; d < 5; d++) begin
                glyph[d] = {1'b0, alt_upper ? shown[4*(d+5) +: 4] : shown[4*d +: 4]};
            end
        end else begin
            for (int d = 0; d < 4; d++) begin
                glyph[d] = {1'b0, shown[4*d +: 4]};
            end
        end
    end

    function automatic logic [6:0] glyph_seg(logic [4:0] g);
        case (g)
            5'h00: return 7'h3f;
            5'h01: return 7'h06;
            5'h02: return 7'h5b;
            5'h03: return 7'h4f;
            5'h04: return 7'h66;
            5'h05: return 7'h6d;
            5'h06: return 7'h7d;
            5'h07: return 7'h07;
            5'h08: return 7'h7f;
            5'h09: return 7'h6f;
            5'h0a: return 7'h77;
            5'h0b: return 7'h7c;
            5'h0c: return 7'h39;
            5'h0d: return 7'h5e;
            5'h0e: return 7'h79;
            5'h0f: return 7'h71;
            5'h11: return 7'h76;
            5'h12: return 7'h38;
            default: return 7'h00;
        endcase
    endfunction

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            segments <= 42'h00000000000;
        end else begin
            for (int d = 0; d < 6; d++) begin
                segments[7*d +: 7] <= glyph_seg(glyph[d]);
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_lamp_steady: assert property (@(posedge sys_clk) disable iff (srst)
        lamp_state == LAMP_STEADY |-> lamp_on)
        else $error("lamp not lit in steady state");

    chk_alarm_blink: assert property (@(posedge sys_clk) disable iff (srst)
        (alarm_active || battery_warning) |=> lamp_state == LAMP_BLINK1)
        else $error("alarm did not select fast blink");

    chk_blink1_off: assert property (@(posedge sys_clk) disable iff (srst)
        lamp_state == LAMP_BLINK1 && !lamp_on |-> blink_ms <= BLINK1_OFF_MS)
        else $error("fast blink off phase too long");

    chk_blink2_on: assert property (@(posedge sys_clk) disable iff (srst)
        lamp_state == LAMP_BLINK2 && lamp_on && $past(lamp_on) |-> blink_ms <= BLINK2_ON_MS)
        else $error("slow blink on phase too long");

    chk_offline_dark: assert property (@(posedge sys_clk) disable iff (srst)
        offline && !alarm_active && !battery_warning && !seq_test_active
        |=> !lamp_on)
        else $error("lamp lit while offline");

    chk_mode_step: assert property (@(posedge sys_clk) disable iff (srst)
        mode_press && !opened && $countones(mode_enable) > 1 |=> mode != $past(mode))
        else $error("mode key did not step mode");

    chk_edit_only: assert property (@(posedge sys_clk) disable iff (srst)
        param_value != $past(param_value) && !$past(wr_strobe)
        |-> $past(mode) == MODE_PARAM && $past(opened))
        else $error("parameter changed outside edit mode");

    chk_hold_open: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(opened) |-> $past(hold_done) && $past(set_shift_key))
        else $error("data opened without full hold");

    chk_jog_test: assert property (@(posedge sys_clk) disable iff (srst)
        jog_fwd |-> $past(mode) == MODE_TEST && $past(up_key) ##1 offline)
        else $error("jog outside test mode or not offline");

    chk_lamp_order: assert property (@(posedge sys_clk) disable iff (srst)
        seq_test_active && !alarm_active && !battery_warning
        |=> lamp_state == LAMP_BLINK2)
        else $error("sequence test blink not selected");

    chk_blink_restart: assert property (@(posedge sys_clk) disable iff (srst)
        lamp_change && next_lamp != LAMP_DARK |=> lamp_on && blink_ms == 11'd0)
        else $error("blink did not restart on change");

endmodule

// [tb/panel_operator.sv]
// Operator model pressing panel keys
`timescale 1ns/1ps
module panel_operator (
    // Clock
    input  wire logic sys_clk,
    // Keys, high while pressed
    output logic      mode_escape_key,
    output logic      up_key,
    output logic      down_key,
    output logic      set_shift_key
);
    logic [3:0] keys = 4'h0;
    assign {set_shift_key, down_key, up_key, mode_escape_key} = keys;
    // Press one key for some cycles, then release
    task automatic press(input int k, input int cycles);
        @(posedge sys_clk);
        keys <= 4'h1 << k;
        repeat (cycles) @(posedge sys_clk);
        keys <= 4'h0;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

// [tb/tb_operator_panel.sv]
// Testbench of the operator panel
`timescale 1ns/1ps
module tb_operator_panel;
    import panel_pkg::*;
    localparam int TL = 4;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        wr_strobe = 1'b0;
    logic        rd_strobe = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] rd_data;
    logic [31:0] d;
    logic        servo_ready = 1'b0;
    logic        alarm_active = 1'b0;
    logic        battery_warning = 1'b0;
    logic        seq_test_active = 1'b0;
    logic        loader_test_active = 1'b0;
    logic [39:0] seq_value = 40'h0000012345;
    logic [39:0] monitor_value = 40'h0000012345;
    logic [39:0] alarm_present = 40'h0000000003;
    logic [39:0] alarm_history = 40'h0000000045;
    logic        irq, lamp_on, jog_fwd, jog_rev, offline;
    logic        mode_escape_key, up_key, down_key, set_shift_key;
    logic [41:0] segments;
    int          error_cnt = 0;
    int          compares = 0;
    int          n;

    always #5 sys_clk = ~sys_clk;

    panel_operator panel_operator_inst (.sys_clk, .mode_escape_key, .up_key, .down_key,
        .set_shift_key);
    operator_panel #(.TICK_LEN(TL)) operator_panel_inst (.sys_clk, .srst, .addr, .wr_data,
        .wr_strobe, .rd_strobe, .rd_data, .irq, .mode_escape_key, .up_key, .down_key,
        .set_shift_key, .servo_ready, .alarm_active, .battery_warning, .seq_test_active,
        .loader_test_active, .seq_value, .monitor_value, .alarm_present, .alarm_history,
        .lamp_on, .segments, .jog_fwd, .jog_rev, .offline);

    // ************************************************************
    // Bus tasks and compares
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= v;
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Cycles the lamp holds a level, from when it reaches it
    task automatic span(input logic lvl, output int c);
        c = 0;
        while (lamp_on !== lvl && c < 20000) begin
            @(posedge sys_clk);
            #1 c++;
        end
        c = 0;
        while (lamp_on === lvl && c < 20000) begin
            @(posedge sys_clk);
            #1 c++;
        end
    endtask
    // Waits until the marker digit shows the given glyph
    task automatic wait_seg(input logic [6:0] mark);
        n = 0;
        while (segments[41:35] !== mark && n < 10000) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #600us;
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd(ADDR_CTRL, d); cmp(d, 32'h7f);
        rd(ADDR_STATION, d); cmp(d, 32'h1);
        rd(ADDR_IRQ_MASK, d); cmp(d, 32'h0);
        rd(8'h3c, d); cmp(d, 32'h0);
        cmp(segments, {14'h0000, 7'h3f, 7'h3f, 7'h3f, 7'h06});
        @(posedge sys_clk);
        servo_ready <= 1'b1;
        rd(ADDR_STATUS, d); cmp(d[7:5], {1'b1, LAMP_STEADY});
        @(posedge sys_clk);
        alarm_active <= 1'b1;
        seq_test_active <= 1'b1;
        span(1'b1, n); cmp(n >= 350*TL - 4 && n <= 352*TL + 4, 1);
        span(1'b0, n); cmp(n >= 150*TL - 4 && n <= 152*TL + 4, 1);
        @(posedge sys_clk);
        alarm_active <= 1'b0;
        battery_warning <= 1'b1;
        rd(ADDR_STATUS, d); cmp(d[6:5], LAMP_BLINK1);
        @(posedge sys_clk);
        battery_warning <= 1'b0;
        span(1'b1, n); cmp(n >= 950*TL - 8 && n <= 952*TL + 4, 1);
        span(1'b0, n); cmp(n >= 1200*TL - 4 && n <= 1202*TL + 4, 1);
        rd(ADDR_STATUS, d); cmp(d[6:5], LAMP_BLINK2);
        @(posedge sys_clk);
        seq_test_active <= 1'b0;
        wr(ADDR_IRQ_MASK, 32'h1);
        panel_operator_inst.press(0, 2);
        cmp(irq, 1'b1);
        rd(ADDR_STATUS, d); cmp(d[2:0], MODE_MON);
        rd(ADDR_IRQ_STATUS, d); cmp(d[0], 1'b1);
        cmp(irq, 1'b0);
        wr(ADDR_CTRL, 32'h51);
        panel_operator_inst.press(0, 2);
        panel_operator_inst.press(3, 750*TL);
        rd(ADDR_STATUS, d); cmp(d[4:0], {2'b00, MODE_PARAM});
        panel_operator_inst.press(3, 1010*TL);
        rd(ADDR_STATUS, d); cmp(d[4:0], {2'b10, MODE_PARAM});
        panel_operator_inst.press(1, 2);
        rd(ADDR_PARAM, d); cmp(d, 32'h1);
        panel_operator_inst.press(2, 2);
        rd(ADDR_PARAM, d); cmp(d, 32'h0);
        panel_operator_inst.press(0, 2);
        panel_operator_inst.press(0, 2);
        panel_operator_inst.press(3, 1010*TL);
        rd(ADDR_STATUS, d); cmp(d[4:0], {2'b10, MODE_TEST});
        fork
            panel_operator_inst.press(1, 20);
            begin
                repeat (12) @(posedge sys_clk);
                #1 cmp({jog_fwd, offline, lamp_on}, 3'b110);
            end
        join
        panel_operator_inst.press(0, 2);
        panel_operator_inst.press(0, 2);
        panel_operator_inst.press(3, 1010*TL);
        wait_seg(7'h38);
        cmp(segments, {7'h38, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d});
        wait_seg(7'h76);
        cmp(segments, {7'h76, 7'h3f, 7'h3f, 7'h3f, 7'h3f, 7'h3f});
        stop_test();
    end
endmodule
